// *** logic/atm_pkg.sv ***
// Package: register map, field layout and types for the trigger mode control
package atm_pkg;
	localparam logic [11:0] ATM_OFF_MODE = 12'h000;
	localparam logic [11:0] ATM_OFF_CTRL = 12'h004;
	localparam logic [11:0] ATM_OFF_LIMIT = 12'h008;
	localparam logic [11:0] ATM_OFF_RESULT = 12'h00C;
	localparam logic [11:0] ATM_OFF_STATUS = 12'h010;
	localparam logic [11:0] ATM_OFF_MASK = 12'h014;
	localparam logic [19:0] ATM_DOC_ADDR = 20'hFFF32;
	localparam logic [7:0] ATM_MODE_RESET = 8'h00;
	localparam logic [7:0] ATM_MODE_WMASK = 8'hE3;
	localparam int ATM_POS_TMD_HI = 7;
	localparam int ATM_POS_TMD_LO = 6;
	localparam int ATM_POS_ONESHOT = 5;
	localparam int ATM_POS_SRC_HI = 1;
	localparam int ATM_POS_SRC_LO = 0;
	localparam int ATM_LOCKOUT_CYCLES = 4;
	localparam logic [3:0] ATM_STAT_RESET = 4'h0;
	localparam logic [3:0] ATM_MASK_RESET = 4'h0;
	localparam logic [1:0] ATM_RESP_OKAY = 2'b00;
	localparam logic [1:0] ATM_RESP_SLVERR = 2'b10;
	localparam logic [3:0] ATM_CONV_CYCLES = 4'hA;
	localparam logic [3:0] ATM_WAIT_CYCLES = 4'h5;

	typedef enum logic [1:0] {
		ATM_SRC_TIMER,
		ATM_SRC_EVLINK,
		ATM_SRC_RTC,
		ATM_SRC_ITIMER
	} atm_src_t;

	typedef enum logic [1:0] {
		ATM_TRIG_SOFT,
		ATM_TRIG_HW_NOWAIT,
		ATM_TRIG_HW_WAIT
	} atm_trig_t;

	typedef struct packed {
		logic timer_ch1_interrupt;
		logic event_link_controller;
		logic rtc_alarm_interrupt;
		logic rtc_period_interrupt;
		logic interval_timer_interrupt;
	} atm_events_t;
endpackage

// *** logic/atm_trigger_ctrl.sv ***
// Trigger mode register, trigger selection and conversion sequencing
module atm_trigger_ctrl
	import atm_pkg::*;
#(
	parameter int RESULT_W = 10
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire atm_events_t trig_events,
	input wire logic snooze_mode,
	input wire logic [RESULT_W-1:0] sample_value,
	output logic conv_start,
	output logic conv_busy,
	output logic irq
);
	if (RESULT_W < 1 || RESULT_W > 16) begin : g_bad_width
		$error("RESULT_W must be 1 to 16");
	end

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_CONV
	} atm_state_t;

	logic [7:0] converter_mode_reg_one;
	logic [7:0] next_mode;
	logic conversion_start_bit, next_cs;
	logic comparator_enable_bit, next_ce;
	logic range_check_select, next_rc;
	logic [RESULT_W-1:0] upper_limit_reg, next_ul;
	logic [RESULT_W-1:0] lower_limit_reg, next_ll;
	logic [RESULT_W-1:0] conversion_result_reg, next_res;
	logic [3:0] status, next_status;
	logic [3:0] mask, next_mask;
	atm_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [2:0] lock_cnt, next_lock_cnt;
	logic next_start, next_busy, next_irq;
	logic [4:0] ev_s1, ev_s2, ev_prev, next_ev_prev;
	logic awready, next_awready, wready, next_wready;
	logic bvalid, next_bvalid, rvalid, next_rvalid, arready, next_arready;
	logic [11:0] awaddr_q, next_awaddr_q;
	logic aw_have, next_aw_have, w_have, next_w_have;
	logic [31:0] wdata_q, next_wdata_q;
	logic [3:0] wstrb_q, next_wstrb_q;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;

	// Offsets that map to a register; all others answer with an error
	function automatic logic known_addr(input logic [11:0] a);
		return a == ATM_OFF_MODE || a == ATM_OFF_CTRL ||
			a == ATM_OFF_LIMIT || a == ATM_OFF_RESULT ||
			a == ATM_OFF_STATUS || a == ATM_OFF_MASK;
	endfunction

	function automatic atm_trig_t trig_mode(input logic [7:0] m);
		if (!m[ATM_POS_TMD_HI]) begin
			return ATM_TRIG_SOFT;
		end else if (m[ATM_POS_TMD_LO]) begin
			return ATM_TRIG_HW_WAIT;
		end
		return ATM_TRIG_HW_NOWAIT;
	endfunction

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ev_s1 <= 5'h00;
			ev_s2 <= 5'h00;
		end else begin
			ev_s1 <= trig_events;
			ev_s2 <= ev_s1;
		end
	end

	atm_trig_t tmode;
	atm_src_t src;
	logic [4:0] ev_rise;
	logic hw_trig, sw_go, do_write, in_range, stopped;
	logic [31:0] wd;

	always_comb begin
		tmode = trig_mode(converter_mode_reg_one);
		src = atm_src_t'({converter_mode_reg_one[ATM_POS_SRC_HI],
			converter_mode_reg_one[ATM_POS_SRC_LO]});
		ev_rise = ev_s2 & ~ev_prev;
		next_ev_prev = ev_s2;
		next_lock_cnt = (lock_cnt != 3'h0) ? lock_cnt - 3'h1 : 3'h0;
		hw_trig = 1'b0;
		case (src)
			ATM_SRC_TIMER: hw_trig = ev_rise[4];
			ATM_SRC_EVLINK: hw_trig = ev_rise[3];
			ATM_SRC_RTC, ATM_SRC_ITIMER: begin
				if (src == ATM_SRC_RTC) begin
					hw_trig = ev_rise[2] | ev_rise[1];
				end else begin
					hw_trig = ev_rise[0];
				end
				if (hw_trig && !snooze_mode) begin
					if (lock_cnt != 3'h0) begin
						hw_trig = 1'b0;
					end else begin
						next_lock_cnt = 3'(ATM_LOCKOUT_CYCLES - 1);
					end
				end
			end
			default: hw_trig = 1'b0;
		endcase
		stopped = !conversion_start_bit && !comparator_enable_bit;
		in_range = (sample_value >= lower_limit_reg &&
			sample_value <= upper_limit_reg) ^ range_check_select;
	end

	// Register bus: address and data accepted in either order
	always_comb begin
		next_awready = awready;
		next_wready = wready;
		next_arready = arready;
		next_aw_have = aw_have;
		next_w_have = w_have;
		next_awaddr_q = awaddr_q;
		next_wdata_q = wdata_q;
		next_wstrb_q = wstrb_q;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		do_write = 1'b0;
		if (s_axi_awvalid && awready) begin
			next_aw_have = 1'b1;
			next_awaddr_q = s_axi_awaddr;
			next_awready = 1'b0;
		end
		if (s_axi_wvalid && wready) begin
			next_w_have = 1'b1;
			next_wdata_q = s_axi_wdata;
			next_wstrb_q = s_axi_wstrb;
			next_wready = 1'b0;
		end
		if (aw_have && w_have && !bvalid) begin
			do_write = 1'b1;
			next_bvalid = 1'b1;
			next_bresp = known_addr(awaddr_q) ? ATM_RESP_OKAY : ATM_RESP_SLVERR;
			next_aw_have = 1'b0;
			next_w_have = 1'b0;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
		if (s_axi_arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = known_addr(s_axi_araddr) ? ATM_RESP_OKAY : ATM_RESP_SLVERR;
			case (s_axi_araddr)
				ATM_OFF_MODE: next_rdata = {24'h000000, converter_mode_reg_one};
				ATM_OFF_CTRL: next_rdata = {29'h00000000, range_check_select,
					comparator_enable_bit, conversion_start_bit};
				ATM_OFF_LIMIT: next_rdata = {16'(upper_limit_reg),
					16'(lower_limit_reg)};
				ATM_OFF_RESULT: next_rdata = {16'h0000, 16'(conversion_result_reg)};
				ATM_OFF_STATUS: next_rdata = {28'h0000000, status};
				ATM_OFF_MASK: next_rdata = {28'h0000000, mask};
				default: next_rdata = 32'h00000000;
			endcase
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	// Register writes, conversion sequencing and interrupt status
	always_comb begin
		wd = wdata_q;
		next_mode = converter_mode_reg_one;
		next_cs = conversion_start_bit;
		next_ce = comparator_enable_bit;
		next_rc = range_check_select;
		next_ul = upper_limit_reg;
		next_ll = lower_limit_reg;
		next_mask = mask;
		next_res = conversion_result_reg;
		next_status = status;
		next_state = state;
		next_cnt = cnt;
		next_start = 1'b0;
		sw_go = 1'b0;
		if (s_axi_arvalid && arready && s_axi_araddr == ATM_OFF_STATUS) begin
			next_status = ATM_STAT_RESET;
		end
		if (do_write && wstrb_q[0]) begin
			case (awaddr_q)
				ATM_OFF_MODE: begin
					if (stopped) begin
						next_mode = wd[7:0] & ATM_MODE_WMASK;
					end else begin
						next_status[3] = 1'b1;
					end
				end
				ATM_OFF_CTRL: begin
					next_cs = wd[0];
					next_ce = wd[1];
					next_rc = wd[2];
					sw_go = wd[0] && !conversion_start_bit;
				end
				ATM_OFF_LIMIT: begin
					next_ll = wd[RESULT_W-1:0];
					next_ul = wd[16+RESULT_W-1:16];
				end
				ATM_OFF_MASK: next_mask = wd[3:0];
				default: next_mask = mask;
			endcase
		end
		case (state)
			ST_IDLE: begin
				if ((tmode == ATM_TRIG_SOFT && sw_go && next_ce) ||
					(tmode != ATM_TRIG_SOFT && hw_trig &&
					conversion_start_bit && comparator_enable_bit)) begin
					next_start = 1'b1;
					if (tmode == ATM_TRIG_HW_WAIT) begin
						next_state = ST_WAIT;
						next_cnt = ATM_WAIT_CYCLES;
					end else begin
						next_state = ST_CONV;
						next_cnt = ATM_CONV_CYCLES;
					end
				end else if (tmode == ATM_TRIG_SOFT && conversion_start_bit &&
					comparator_enable_bit && !converter_mode_reg_one[5] &&
					conv_busy == 1'b0 && status[0] == 1'b0) begin
					next_start = 1'b1; // Sequential mode restarts
					next_state = ST_CONV;
					next_cnt = ATM_CONV_CYCLES;
				end
			end
			ST_WAIT: begin
				next_cnt = cnt - 4'h1;
				if (cnt == 4'h1) begin
					next_state = ST_CONV;
					next_cnt = ATM_CONV_CYCLES;
				end
			end
			ST_CONV: begin
				next_cnt = cnt - 4'h1;
				if (cnt == 4'h1) begin
					next_state = ST_IDLE;
					if (tmode != ATM_TRIG_HW_WAIT || in_range) begin
						next_res = sample_value;
						next_status[0] = 1'b1;
					end else begin
						next_status[1] = 1'b1;
					end
					if (converter_mode_reg_one[ATM_POS_ONESHOT]) begin
						next_cs = 1'b0;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (hw_trig && state != ST_IDLE) begin
			next_status[2] = 1'b1;
		end
		next_busy = next_state != ST_IDLE;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			converter_mode_reg_one <= ATM_MODE_RESET;
			conversion_start_bit <= 1'b0;
			comparator_enable_bit <= 1'b0;
			range_check_select <= 1'b0;
			upper_limit_reg <= '1;
			lower_limit_reg <= '0;
			conversion_result_reg <= '0;
			status <= ATM_STAT_RESET;
			mask <= ATM_MASK_RESET;
			state <= ST_IDLE;
			cnt <= 4'h0;
			lock_cnt <= 3'h0;
			ev_prev <= 5'h00;
			conv_start <= 1'b0;
			conv_busy <= 1'b0;
			irq <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			arready <= 1'b1;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= ATM_RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= ATM_RESP_OKAY;
			rdata <= 32'h00000000;
		end else begin
			converter_mode_reg_one <= next_mode;
			conversion_start_bit <= next_cs;
			comparator_enable_bit <= next_ce;
			range_check_select <= next_rc;
			upper_limit_reg <= next_ul;
			lower_limit_reg <= next_ll;
			conversion_result_reg <= next_res;
			status <= next_status;
			mask <= next_mask;
			state <= next_state;
			cnt <= next_cnt;
			lock_cnt <= next_lock_cnt;
			ev_prev <= next_ev_prev;
			conv_start <= next_start;
			conv_busy <= next_busy;
			irq <= next_irq;
			awready <= next_awready;
			wready <= next_wready;
			arready <= next_arready;
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			awaddr_q <= next_awaddr_q;
			wdata_q <= next_wdata_q;
			wstrb_q <= next_wstrb_q;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	assign s_axi_awready = awready;
	assign s_axi_wready = wready;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = arready;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
endmodule

// *** verification/atm_event_src.sv ***
// Trigger source model: timers, RTC and event link as edge pulses
module atm_event_src
	import atm_pkg::*;
(
	input wire logic core_clk,
	input wire logic [4:0] fire,
	output atm_events_t trig_events
);
	timeunit 1ns;
	timeprecision 1ns;
	// Lines rise only on request; the bench spaces requests apart
	always @(posedge core_clk)
		trig_events <= fire;
endmodule

// *** verification/atm_trigger_ctrl_bench.sv ***
// Self-checking bench for the trigger mode control block
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
	num_errors++; $display("FAIL %s exp %0h got %0h", nm, e, a); end end
module atm_trigger_ctrl_bench
	import atm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0;
	logic rst = 1;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, snooze_mode = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, v;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, conv_start, conv_busy, irq;
	logic [9:0] sample_value = 0, last;
	logic [4:0] fire = 0;
	atm_events_t trig_events;
	int num_errors = 0, cmp_count = 0, seed = 66, i, s, len;
	int eb[4] = '{4, 3, 2, 0};
	always #10 core_clk = ~core_clk;
	atm_trigger_ctrl atm_trigger_ctrl_inst (.core_clk, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.trig_events, .snooze_mode, .sample_value, .conv_start,
		.conv_busy, .irq);
	atm_event_src atm_event_src_inst (.core_clk, .fire, .trig_events);
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] st);
		int k;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (k = 0; k < 60; k++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (w ? s_axi_bvalid : s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		resp = w ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		if (k == 60) begin
			num_errors++;
			wrap_up();
		end
	endtask
	// Pulse one event line (twice if dbl) and count busy cycles after it
	task automatic trig(input int b, input logic dbl);
		int k;
		@(posedge core_clk);
		fire <= 5'h1 << b;
		sample_value <= 10'($random(seed)) | 10'h200;
		@(posedge core_clk);
		fire <= 0;
		@(posedge core_clk);
		fire <= dbl ? 5'h1 << b : 5'h0;
		len = 0;
		for (k = 0; k < 40; k++) begin
			@(posedge core_clk);
			fire <= 0;
			len += conv_busy;
		end
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 0;
		bus(0, ATM_OFF_MODE, 0, 0);
		`CHK("mode reset", 32'h0, rd)
		bus(0, 12'h0F0, 0, 0);
		`CHK("unmapped", ATM_RESP_SLVERR, resp)
		bus(1, 12'h0F0, 0, 4'hF);
		`CHK("unmapped write", ATM_RESP_SLVERR, resp)
		for (i = 0; i < 8; i++) begin
			v = i ? $random(seed) : 32'hFF;
			bus(1, ATM_OFF_MODE, v, 4'hF);
			bus(1, ATM_OFF_MODE, ~v, 4'hE);
			bus(0, ATM_OFF_MODE, 0, 0);
			`CHK("mode", {24'h0, v[7:0] & 8'hE3}, rd)
		end
		bus(1, ATM_OFF_MASK, 1, 4'hF);
		for (i = 0; i < 8; i++) begin
			s = i % 4;
			v = (i < 4 ? 32'hA0 : 32'hE0) | s;
			bus(1, ATM_OFF_CTRL, 0, 4'hF);
			bus(1, ATM_OFF_MODE, v, 4'hF);
			bus(1, ATM_OFF_CTRL, 3, 4'hF);
			trig(eb[(s + 1) % 4], 0);
			`CHK("other source", 0, len)
			trig(eb[s], 0);
			`CHK("busy", (i < 4 ? 10 : 15), len)
			bus(1, ATM_OFF_MODE, 0, 4'hF);
			bus(0, ATM_OFF_MODE, 0, 0);
			`CHK("mode locked", v, rd)
			bus(0, ATM_OFF_CTRL, 0, 0);
			`CHK("one-shot", 32'h2, rd)
			`CHK("irq set", 1'b1, irq)
			bus(0, ATM_OFF_RESULT, 0, 0);
			`CHK("result", {22'h0, sample_value}, rd)
			bus(0, ATM_OFF_STATUS, 0, 0);
			`CHK("status", 32'h9, rd)
			repeat (2) @(posedge core_clk);
			`CHK("irq clear", 1'b0, irq)
		end
		bus(1, ATM_OFF_CTRL, 0, 4'hF);
		bus(1, ATM_OFF_MODE, 8'hE3, 4'hF);
		bus(1, ATM_OFF_LIMIT, 32'h01FF0000, 4'hF);
		bus(1, ATM_OFF_CTRL, 3, 4'hF);
		last = sample_value;
		trig(0, 0);
		`CHK("reject irq", 1'b0, irq)
		bus(0, ATM_OFF_RESULT, 0, 0);
		`CHK("kept result", {22'h0, last}, rd)
		bus(0, ATM_OFF_STATUS, 0, 0);
		`CHK("reject", 32'h2, rd)
		for (i = 0; i < 4; i++) begin
			bus(1, ATM_OFF_CTRL, 0, 4'hF);
			bus(1, ATM_OFF_MODE, 8'hA2 | i[0], 4'hF);
			bus(1, ATM_OFF_CTRL, 3, 4'hF);
			snooze_mode <= i[1];
			trig(i[0] ? 0 : 1, 1);
			bus(0, ATM_OFF_STATUS, 0, 0);
			`CHK("lockout", (i[1] ? 32'h5 : 32'h1), rd)
		end
		bus(1, ATM_OFF_CTRL, 0, 4'hF);
		bus(1, ATM_OFF_MODE, 8'h60, 4'hF);
		bus(1, ATM_OFF_CTRL, 2, 4'hF);
		trig(4, 0);
		`CHK("hw in soft", 0, len)
		bus(1, ATM_OFF_CTRL, 3, 4'hF);
		trig(5, 0);
		`CHK("soft start", 1'b1, len > 0)
		wrap_up();
	end
endmodule

// *** verification/atm_trigger_ctrl_chk.sv ***
// Checker of bus handshakes and conversion outputs
module atm_trigger_ctrl_chk
	import atm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_awready,
	input wire logic conv_start,
	input wire logic conv_busy,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [11:0] ar_q;
	logic [11:0] next_ar_q;
	always_comb
		next_ar_q = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_q;
	always_ff @(posedge core_clk)
		ar_q <= next_ar_q;
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	property p_wr_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("address open early");
	property p_mode_zero;
		s_axi_rvalid && ar_q == ATM_OFF_MODE |->
			s_axi_rdata[4:2] == 3'h0 && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_mode_zero: assert property (p_mode_zero) else $error("mode bits set");
	property p_start_pulse;
		conv_start |=> !conv_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("long start");
	property p_busy_run;
		conv_start |=> conv_busy [*8];
	endproperty
	a_busy_run: assert property (p_busy_run) else $error("short busy");
	property p_reset_quiet;
		$past(rst) |-> !irq && !conv_busy && !s_axi_rvalid && !s_axi_bvalid;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("reset state");
	cover property (conv_start);
	cover property (irq);
	cover property (s_axi_rvalid && ar_q == ATM_OFF_MODE);
endmodule

bind atm_trigger_ctrl atm_trigger_ctrl_chk atm_trigger_ctrl_chk_inst (
	.core_clk, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_awready, .conv_start, .conv_busy, .irq);
